// ==== rtl/coprocessor_instr_dispatch.sv ====
`timescale 1ns/1ps
module coprocessor_instr_dispatch (
  input wire logic core_clk, // Core clock, 100 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic core_req_valid, // Core has a coprocessor op pending
  input wire logic [1:0] core_req_class, // Op class: arith, to, from
  input wire logic [31:0] core_req_word, // Op instruction word
  input wire logic core_big_endian, // Core byte order
  input wire logic core_priv, // Core in kernel or debug mode
  output logic core_req_ready, // Op was presented this cycle
  input wire logic arith_stall, // Coprocessor arithmetic busy
  input wire logic to_cop_stall, // Coprocessor to-transfer busy
  input wire logic from_cop_stall, // Coprocessor from-transfer busy
  output logic [31:0] cop_instr_word, // Instruction word to coprocessor
  output logic instr_capture_gate, // Late capture enable
  output logic arith_dispatch_strobe, // Arithmetic strobe
  output logic to_cop_strobe, // To-coprocessor strobe
  output logic from_cop_strobe, // From-coprocessor strobe
  output logic big_endian_flag, // High for big-endian
  output logic privileged_mode_flag, // High in kernel or debug
  output logic narrow_isa_flag // Always high
);
  typedef enum logic [1:0] {idle_st, present_st} phase_t;

  cop_issue_if req ();

  logic arith_stall_s;
  logic to_stall_s;
  logic from_stall_s;
  logic [31:0] word_q;
  logic gate_q;
  logic as_q;
  logic ts_q;
  logic fs_q;
  logic endian_q;
  logic priv_q;
  logic isa_q;
  logic [1:0] class_q;
  phase_t phase_q;
  phase_t phase_d;
  logic class_stalled;
  logic present_now;
  logic fire_arith;
  logic fire_to;
  logic fire_from;
  logic fire_any;

  // Core request onto the internal carrier
  assign req.req_valid = core_req_valid;
  assign req.req_class = core_req_class;
  assign req.req_word = core_req_word;
  assign req.req_big_endian = core_big_endian;
  assign req.req_priv = core_priv;
  assign core_req_ready = req.req_ready;

  // Stall inputs come from another block's pins, so synchronise them
  stall_sync u_sync_arith (.core_clk(core_clk), .rst(rst), .raw_in(arith_stall), .sync_out(arith_stall_s));
  stall_sync u_sync_to (.core_clk(core_clk), .rst(rst), .raw_in(to_cop_stall), .sync_out(to_stall_s));
  stall_sync u_sync_from (.core_clk(core_clk), .rst(rst), .raw_in(from_cop_stall), .sync_out(from_stall_s));

  // Stall of the class already on the word output; the raw stall last cycle
  // is what the coprocessor sees, the synchronised copy is a safe superset
  assign class_stalled = (class_q == cop_dispatch_pkg::class_arith) ? (arith_stall_s | arith_stall) :
                         (class_q == cop_dispatch_pkg::class_to) ? (to_stall_s | to_cop_stall) :
                         (class_q == cop_dispatch_pkg::class_from) ? (from_stall_s | from_cop_stall) : 1'b1;

  // Strobe decode: only one class held, so the strobes are exclusive
  assign fire_any = (phase_q == present_st) && gate_q && !class_stalled;
  assign fire_arith = fire_any && (class_q == cop_dispatch_pkg::class_arith);
  assign fire_to = fire_any && (class_q == cop_dispatch_pkg::class_to);
  assign fire_from = fire_any && (class_q == cop_dispatch_pkg::class_from);

  // A new op is taken when nothing is held or the held one is issuing now
  assign present_now = req.req_valid && (req.req_class != cop_dispatch_pkg::class_none) &&
                       ((phase_q == idle_st) || fire_any);
  assign req.req_ready = present_now;

  // Phase: present_st means a word sits on the output awaiting its strobe
  always_comb
  begin
    phase_d = phase_q;
    unique case (phase_q)
      idle_st: if (present_now) phase_d = present_st;
      present_st: if (fire_any && !present_now) phase_d = idle_st;
      default: phase_d = idle_st;
    endcase
  end

  // Word, class and flags are loaded together at least one cycle before the strobe
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      word_q <= cop_dispatch_pkg::instr_reset;
      class_q <= cop_dispatch_pkg::class_none;
      endian_q <= cop_dispatch_pkg::big_endian_reset;
      priv_q <= cop_dispatch_pkg::priv_reset;
    end
    else if (present_now)
    begin
      word_q <= req.req_word;
      class_q <= req.req_class;
      endian_q <= req.req_big_endian;
      priv_q <= req.req_priv;
    end
  end

  // Gate goes high with a presented word and stays while it waits; it is
  // kept registered here, the coprocessor may only clock-gate with it
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      phase_q <= idle_st;
      gate_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      gate_q <= (phase_d == present_st);
    end
  end

  // Strobes registered so the outputs come straight from flops
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      as_q <= 1'b0;
      ts_q <= 1'b0;
      fs_q <= 1'b0;
      isa_q <= cop_dispatch_pkg::narrow_isa_value;
    end
    else
    begin
      as_q <= fire_arith;
      ts_q <= fire_to;
      fs_q <= fire_from;
      isa_q <= cop_dispatch_pkg::narrow_isa_value;
    end
  end

  // Copies of last cycle's word, gate and flags; the lead-time checks below
  // compare against them, since the outputs themselves already lead the strobe
  logic [31:0] word_out_q;
  logic gate_out_q;
  logic endian_out_q;
  logic priv_out_q;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      word_out_q <= cop_dispatch_pkg::instr_reset;
      gate_out_q <= 1'b0;
      endian_out_q <= cop_dispatch_pkg::big_endian_reset;
      priv_out_q <= cop_dispatch_pkg::priv_reset;
    end
    else
    begin
      word_out_q <= word_q;
      gate_out_q <= gate_q;
      endian_out_q <= endian_q;
      priv_out_q <= priv_q;
    end
  end

  // Outputs: word, flags and gate are loaded at the take, the strobe is decided
  // one cycle later at the earliest from the raw and synchronised stalls, so they lead the strobe by at least one cycle
  assign cop_instr_word = word_q;
  assign instr_capture_gate = gate_q;
  assign big_endian_flag = endian_q;
  assign privileged_mode_flag = priv_q;
  assign narrow_isa_flag = isa_q;
  assign arith_dispatch_strobe = as_q;
  assign to_cop_strobe = ts_q;
  assign from_cop_strobe = fs_q;

  // OR of the three registered strobes, used only by the checks below
  logic any_strobe;
  assign any_strobe = as_q | ts_q | fs_q;

  sequence gate_low_s;
    !instr_capture_gate;
  endsequence

  sequence gate_high_s;
    instr_capture_gate;
  endsequence

  strobe_onehot_a: assert property (@(posedge core_clk) disable iff (rst)
    $onehot0({as_q, ts_q, fs_q})) else $error("More than one strobe high");
  gate_blocks_a: assert property (@(posedge core_clk) disable iff (rst)
    gate_low_s |=> !any_strobe) else $error("Strobe after capture gate low");
  strobe_needs_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    any_strobe |-> $past(gate_q)) else $error("Strobe without gate the cycle before");
  arith_stall_a: assert property (@(posedge core_clk) disable iff (rst)
    arith_stall |=> !as_q) else $error("Arithmetic strobe after stall");
  to_stall_a: assert property (@(posedge core_clk) disable iff (rst)
    to_cop_stall |=> !ts_q) else $error("To strobe after stall");
  from_stall_a: assert property (@(posedge core_clk) disable iff (rst)
    from_cop_stall |=> !fs_q) else $error("From strobe after stall");
  isa_high_a: assert property (@(posedge core_clk) disable iff (rst)
    narrow_isa_flag) else $error("Narrow ISA flag low");
  reset_quiet_a: assert property (@(posedge core_clk)
    rst |=> !any_strobe && !gate_q) else $error("Strobe or gate during reset");
  arith_class_a: assert property (@(posedge core_clk) disable iff (rst)
    as_q |-> $past(class_q) == cop_dispatch_pkg::class_arith) else $error("Arith strobe wrong class");
  to_class_a: assert property (@(posedge core_clk) disable iff (rst)
    ts_q |-> $past(class_q) == cop_dispatch_pkg::class_to) else $error("To strobe wrong class");
  from_class_a: assert property (@(posedge core_clk) disable iff (rst)
    fs_q |-> $past(class_q) == cop_dispatch_pkg::class_from) else $error("From strobe wrong class");
  word_lead_a: assert property (@(posedge core_clk) disable iff (rst)
    gate_high_s ##0 (phase_q == present_st) |-> ##0 (word_q == $past(word_q) || $past(present_now)))
    else $error("Word moved while held");

  // A held word and its flags must not move until the strobe has gone out
  held_word_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(gate_q && !fire_any) |-> word_q == word_out_q) else $error("Word changed before its strobe");
  held_endian_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(gate_q && !fire_any) |-> endian_q == endian_out_q) else $error("Byte order changed before strobe");
  held_priv_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(gate_q && !fire_any) |-> priv_q == priv_out_q) else $error("Mode flag changed before strobe");
  strobe_gate_prev_a: assert property (@(posedge core_clk) disable iff (rst)
    any_strobe |-> gate_out_q) else $error("Strobe without gate in the cycle before");
endmodule

// ==== rtl/cop_dispatch_pkg.sv ====
package cop_dispatch_pkg;
  localparam int unsigned instr_w = 32;
  localparam logic [31:0] instr_reset = 32'h0000_0000;
  localparam logic narrow_isa_value = 1'b1;
  localparam logic big_endian_reset = 1'b0;
  localparam logic priv_reset = 1'b1;
  localparam logic [1:0] class_arith = 2'h0;
  localparam logic [1:0] class_to = 2'h1;
  localparam logic [1:0] class_from = 2'h2;
  localparam logic [1:0] class_none = 2'h3;
endpackage

// ==== rtl/cop_issue_if.sv ====
`timescale 1ns/1ps
// Carries one pending request from the core side into the issue stage
interface cop_issue_if;
  logic req_valid;
  logic [1:0] req_class;
  logic [31:0] req_word;
  logic req_big_endian;
  logic req_priv;
  logic req_ready;
  modport core (output req_valid, req_class, req_word, req_big_endian, req_priv, input req_ready);
  modport issue (input req_valid, req_class, req_word, req_big_endian, req_priv, output req_ready);
endinterface

// ==== rtl/stall_sync.sv ====
`timescale 1ns/1ps
// Two-flop synchroniser for the coprocessor stall inputs
module stall_sync (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Synchronous reset
  input wire logic raw_in, // Asynchronous level
  output logic sync_out // Synchronised level
);
  logic meta_q;
  logic sync_q;

  // Reset to busy so nothing issues before the stall is really known
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end
    else
    begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// ==== verification/cop_model.sv ====
`timescale 1ns/1ps
// Attached coprocessor: stalls on command and captures what is dispatched
module cop_model (
  input wire logic core_clk, // Core clock
  input wire logic [2:0] hold, // Busy request: arith, to, from
  input wire logic [31:0] cop_instr_word, // Word from core
  input wire logic instr_capture_gate, // Late capture enable
  input wire logic big_endian_flag, // Byte order
  input wire logic privileged_mode_flag, // Mode flag
  output logic [2:0] stall_q, // Busy lines: arith, to, from
  output logic [33:0] cap_q // Captured flags and word
);
  // Busy lines change only after an edge, like registered logic would
  always_ff @(posedge core_clk)
  begin
    stall_q <= hold;
  end
  // Gate is late, so it only enables the capture flops and feeds nothing else
  always_ff @(posedge core_clk)
  begin
    if (instr_capture_gate)
    begin
      cap_q <= {big_endian_flag, privileged_mode_flag, cop_instr_word};
    end
  end
endmodule

// ==== verification/coprocessor_instr_dispatch_tb_top.sv ====
`timescale 1ns/1ps
module coprocessor_instr_dispatch_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic [1:0] req_class = 2'h3;
  logic [31:0] req_word = 32'h0000_0000;
  logic req_be = 1'b0;
  logic req_priv = 1'b0;
  logic [2:0] hold = 3'h0;
  logic ready, gate, ir_be, ir_priv, isa;
  logic [31:0] ir_word;
  wire [2:0] strobes;
  wire [2:0] stall;
  logic [33:0] cap;
  logic rdy_s = 1'b0;
  logic gate_p = 1'b0;
  logic [2:0] stall_p = 3'h0;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  always #5 core_clk = ~core_clk;
  coprocessor_instr_dispatch coprocessor_instr_dispatch_i (.core_clk(core_clk), .rst(rst),
    .core_req_valid(req_valid), .core_req_class(req_class), .core_req_word(req_word),
    .core_big_endian(req_be), .core_priv(req_priv), .core_req_ready(ready),
    .arith_stall(stall[0]), .to_cop_stall(stall[1]), .from_cop_stall(stall[2]),
    .cop_instr_word(ir_word), .instr_capture_gate(gate), .arith_dispatch_strobe(strobes[0]),
    .to_cop_strobe(strobes[1]), .from_cop_strobe(strobes[2]), .big_endian_flag(ir_be),
    .privileged_mode_flag(ir_priv), .narrow_isa_flag(isa));
  cop_model cop_model_i (.core_clk(core_clk), .hold(hold), .cop_instr_word(ir_word),
    .instr_capture_gate(gate), .big_endian_flag(ir_be), .privileged_mode_flag(ir_priv),
    .stall_q(stall), .cap_q(cap));
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  // Watch every edge; pre-edge values pair each strobe with the cycle before it
  always @(posedge core_clk)
  begin
    rdy_s <= ready;
    gate_p <= gate;
    stall_p <= stall;
    cycles <= cycles + 1;
    if (rst && cycles > 1)
      check("reset outputs", 34'h0, 34'({strobes, gate}));
    if (strobes !== 3'h0)
    begin
      check("gate before strobe", 34'h1, 34'(gate_p));
      check("one strobe", 34'h1, 34'($onehot(strobes)));
      check("stall before strobe", 34'h0, 34'(strobes & stall_p));
    end
    // Ceiling well above the hundred or so cycles the tests need
    if (cycles == 5000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic send(input logic [1:0] cls, input logic [31:0] w, input logic be, input logic pv);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_class = cls;
    req_word = w;
    req_be = be;
    req_priv = pv;
    do
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    while (!rdy_s && n < 40);
    req_valid = 1'b0;
    check("taken", 34'h1, 34'(rdy_s));
  endtask
  task automatic expect_strobe(input logic [1:0] cls, input logic [33:0] expcap);
    int n;
    n = 0;
    while (strobes === 3'h0 && n < 40)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("strobe", 34'(3'h1 << cls), 34'(strobes));
    check("word and flags captured", expcap, cap);
  endtask
  // Dispatch of every class in turn, each awaiting its strobe, with varied flags
  task automatic dispatch_test();
    for (int c = 0; c < 3; c++)
    begin
      send(2'(c), 32'h4a00_0011 + 32'(c), c[0], ~c[0]);
      expect_strobe(2'(c), {c[0], ~c[0], 32'h4a00_0011 + 32'(c)});
    end
  endtask
  // Each class held off by its own busy line, then released
  task automatic stall_test();
    logic [2:0] seen;
    for (int c = 0; c < 3; c++)
    begin
      seen = 3'h0;
      hold = 3'h1 << c;
      repeat (3) @(posedge core_clk);
      #1;
      send(2'(c), 32'h4b10_0000 + 32'(c), 1'b1, 1'b0);
      repeat (12)
      begin
        @(posedge core_clk);
        #1;
        seen = seen | strobes;
      end
      check("held strobe", 34'h0, 34'(seen));
      hold = 3'h0;
      expect_strobe(2'(c), {2'b10, 32'h4b10_0000 + 32'(c)});
    end
  endtask
  // Class none gives neither gate nor strobe
  task automatic none_test();
    logic [3:0] seen;
    seen = 4'h0;
    req_valid = 1'b1;
    req_class = 2'h3;
    repeat (10)
    begin
      @(posedge core_clk);
      #1;
      seen = seen | {strobes, gate};
    end
    req_valid = 1'b0;
    check("none class quiet", 34'h0, 34'(seen));
  endtask
  initial
  begin
    repeat (16) @(posedge core_clk);
    #1;
    rst = 1'b0;
    check("narrow isa flag", 34'h1, 34'(isa));
    dispatch_test();
    stall_test();
    none_test();
    report_and_stop();
  end
endmodule
